// ---- rtl/see_pkg.sv ----
// Purpose: Constants and types shared by the serial EEPROM block.
// Assumes: A 25 MHz local clock and a host-driven serial clock.
// Notes: Opcodes are sent most significant bit first.
`default_nettype none

package see_pkg;
  // Array and page geometry.
  localparam int ADDR_W = 11;
  localparam int OFS_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 2048;
  localparam logic [OFS_W-1:0] IDX_LAST = 5'h1F;
  localparam logic [1:0] SEG_TOP = 2'h3;
  // Bit counter end points on the link.
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] ADDR_LAST = 4'hF;
  // Opcodes.
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_ARRAY = 8'h03;
  localparam logic [7:0] OP_WRITE_ARRAY = 8'h02;
  // Status byte layout and values.
  localparam int WRITE_BUSY_BIT = 0;
  localparam int WRITE_LATCH_BIT = 1;
  localparam int BLOCK_PROTECT_LO = 2;
  localparam int BLOCK_PROTECT_HI = 3;
  localparam int PROTECT_PIN_ENABLE_BIT = 7;
  localparam logic [7:0] STAT_BUSY_VAL = 8'hFF;
  localparam logic [1:0] BP_TOP_QUARTER = 2'h1;
  localparam logic [1:0] BP_TOP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  // Reset values of the protection settings.
  localparam logic PROTECT_PIN_ENABLE_BIT_RST = 1'h0;
  localparam logic [1:0] BP_RST = 2'h0;
  // Self-timed write duration.
  localparam int WCNT_W = 18;
  localparam int WRITE_TIME_NS = 10_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_NS / CLK_PERIOD_NS;
  // Link phases and write engine states.
  typedef enum logic [2:0] {
    PH_DEAD, PH_OP, PH_ADDR, PH_RDATA, PH_RSTAT, PH_WDATA, PH_WSTAT,
    PH_IGNORE
  } see_phase_t;
  typedef enum logic [1:0] {W_IDLE, W_COPY, W_STAT, W_WAIT} see_wstate_t;
endpackage : see_pkg

`default_nettype wire

// ---- rtl/see_spi_eeprom.sv ----
// Purpose: Serial command logic of a 2K x 8 serial EEPROM slave.
// Assumes: Host keeps chip select high at least 2 us between frames.
// Notes: Link side runs on the serial clock, the write engine on ref_clk_in.
`default_nettype none

module see_spi_eeprom import see_pkg::*; #(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  // Local clock and reset.
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Serial link from the host.
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic hold_n_in,
  output logic so_out,
  output logic so_oe_out,
  // Protection pin and engine status.
  input wire logic wp_n_in,
  output logic busy_out
);

  // Link domain state.
  see_phase_t phase_reg;
  logic fresh_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] op_reg;
  logic [7:0] stat_data_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [PAGE_BYTES-1:0] mask_reg;
  logic wr_ok_reg;
  logic latch_ok_reg;
  logic load_reg;
  logic busy_l1_reg;
  logic busy_l2_reg;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [7:0] tx_reg;
  logic so_reg;
  logic oe_reg;
  logic [7:0] rx_byte;
  logic [7:0] byte_src;
  logic fresh_clr;
  logic oe_kill;
  // Local domain state.
  see_wstate_t wstate_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic wp_s1_reg, wp_s2_reg;
  logic wok_s1_reg, wok_s2_reg;
  logic lok_s1_reg, lok_s2_reg;
  logic busy_reg;
  logic wel_reg;
  logic protect_pin_enable_bit_reg;
  logic [1:0] bp_reg;
  logic [7:0] stat_rd_reg;
  logic [7:0] stat_next;
  logic [OFS_W-1:0] idx_reg;
  logic [WCNT_W-1:0] wcnt_reg;
  logic [7:0] mem [MEM_BYTES];
  logic cs_rise;
  logic prot_arr;
  logic hw_lock;
  logic go_arr;
  logic go_stat;

  assign rx_byte = {sh_reg[6:0], si_in};
  assign fresh_clr = srst_in & ~cs_n_in;
  assign oe_kill = cs_n_in | ~hold_n_in | srst_in;
  assign so_out = so_reg;
  assign so_oe_out = oe_reg;
  assign busy_out = busy_reg;

  // Marks that the next serial clock rise opens a new frame. Only a high
  // chip select sets it, so a frame already running at reset is ignored.
  always_ff @(posedge sck_in or posedge cs_n_in or posedge fresh_clr) begin
    if (cs_n_in) begin
      fresh_reg <= 1'b1;
    end else if (fresh_clr) begin
      fresh_reg <= 1'b0;
    end else if (hold_n_in) begin
      fresh_reg <= 1'b0;
    end
  end

  // Engine busy is seen by the link after two serial clock edges.
  always_ff @(posedge sck_in or posedge srst_in) begin
    if (srst_in) begin
      busy_l1_reg <= 1'b0;
      busy_l2_reg <= 1'b0;
    end else begin
      busy_l1_reg <= busy_reg;
      busy_l2_reg <= busy_l1_reg;
    end
  end

  // Command decoder on the serial clock rise. The frame results stay put
  // after chip select rises, which lets the local side pick them up.
  always_ff @(posedge sck_in or posedge srst_in) begin
    if (srst_in) begin
      phase_reg <= PH_DEAD;
      cnt_reg <= '0;
      sh_reg <= '0;
      op_reg <= '0;
      stat_data_reg <= '0;
      addr_reg <= '0;
      mask_reg <= '0;
      wr_ok_reg <= 1'b0;
      latch_ok_reg <= 1'b0;
      load_reg <= 1'b0;
    end else if (hold_n_in) begin
      load_reg <= 1'b0;
      if (fresh_reg) begin
        phase_reg <= PH_OP;
        sh_reg <= {7'h00, si_in};
        cnt_reg <= 4'h1;
        mask_reg <= '0;
        wr_ok_reg <= 1'b0;
        latch_ok_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
        sh_reg <= rx_byte;
        wr_ok_reg <= 1'b0;
        latch_ok_reg <= 1'b0;
        case (phase_reg)
          PH_OP: begin
            if (cnt_reg == BYTE_LAST) begin
              cnt_reg <= '0;
              op_reg <= rx_byte;
              case (rx_byte)
                OP_READ_ARRAY, OP_WRITE_ARRAY: phase_reg <= PH_ADDR;
                OP_READ_STATUS: begin
                  phase_reg <= PH_RSTAT;
                  load_reg <= 1'b1;
                end
                OP_WRITE_STATUS: phase_reg <= PH_WSTAT;
                OP_SET_WRITE_LATCH, OP_CLEAR_WRITE_LATCH: begin
                  phase_reg <= PH_IGNORE;
                  latch_ok_reg <= 1'b1;
                end
                default: phase_reg <= PH_IGNORE;
              endcase
            end
          end
          PH_ADDR: begin
            addr_reg <= {addr_reg[ADDR_W-2:0], si_in};
            if (cnt_reg == ADDR_LAST) begin
              cnt_reg <= '0;
              if (op_reg == OP_READ_ARRAY) begin
                phase_reg <= PH_RDATA;
                load_reg <= 1'b1;
              end else begin
                phase_reg <= PH_WDATA;
              end
            end
          end
          PH_RDATA, PH_RSTAT: begin
            if (cnt_reg == BYTE_LAST) begin
              cnt_reg <= '0;
              load_reg <= 1'b1;
              if (phase_reg == PH_RDATA) begin
                addr_reg <= addr_reg + 11'h001;
              end
            end
          end
          PH_WDATA: begin
            if (cnt_reg == BYTE_LAST) begin
              cnt_reg <= '0;
              if (!busy_l2_reg) begin
                mask_reg[addr_reg[OFS_W-1:0]] <= 1'b1;
                addr_reg[OFS_W-1:0] <= addr_reg[OFS_W-1:0] + 5'h01;
                wr_ok_reg <= 1'b1;
              end
            end
          end
          PH_WSTAT: begin
            if (cnt_reg == BYTE_LAST) begin
              cnt_reg <= '0;
              if (!busy_l2_reg) begin
                stat_data_reg <= rx_byte;
                wr_ok_reg <= 1'b1;
              end
            end
          end
          default: cnt_reg <= '0;
        endcase
      end
    end
  end

  // Page buffer fill; refused while the engine may still be copying it.
  always_ff @(posedge sck_in) begin
    if (hold_n_in && !fresh_reg && phase_reg == PH_WDATA &&
        cnt_reg == BYTE_LAST && !busy_l2_reg) begin
      page_buf[addr_reg[OFS_W-1:0]] <= rx_byte;
    end
  end

  // The array and status are static while a read streams, so the link reads
  // them directly; only a write racing a read would tear a byte.
  assign byte_src = (phase_reg == PH_RSTAT) ? stat_rd_reg : mem[addr_reg];

  // Output shifter on the serial clock fall.
  always_ff @(negedge sck_in or posedge srst_in) begin
    if (srst_in) begin
      tx_reg <= '0;
      so_reg <= 1'b0;
    end else if (hold_n_in) begin
      if (load_reg) begin
        so_reg <= byte_src[7];
        tx_reg <= {byte_src[6:0], 1'b0};
      end else begin
        so_reg <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // Output enable drops at once on deselect or pause, and returns at the
  // next serial clock fall of a read phase.
  always_ff @(negedge sck_in or posedge oe_kill) begin
    if (oe_kill) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= (phase_reg == PH_RDATA) || (phase_reg == PH_RSTAT);
    end
  end

  // Two-stage synchronisers for chip select, the protect pin and the frame
  // result flags.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      wp_s1_reg <= 1'b1;
      wp_s2_reg <= 1'b1;
      wok_s1_reg <= 1'b0;
      wok_s2_reg <= 1'b0;
      lok_s1_reg <= 1'b0;
      lok_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= cs_n_in;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      wp_s1_reg <= wp_n_in;
      wp_s2_reg <= wp_s1_reg;
      wok_s1_reg <= wr_ok_reg;
      wok_s2_reg <= wok_s1_reg;
      lok_s1_reg <= latch_ok_reg;
      lok_s2_reg <= lok_s1_reg;
    end
  end

  // Commit decision at the end of a frame.
  assign cs_rise = cs_s2_reg & ~cs_s3_reg;
  assign prot_arr = (bp_reg == BP_ALL) ||
                    (bp_reg == BP_TOP_HALF && addr_reg[ADDR_W-1]) ||
                    (bp_reg == BP_TOP_QUARTER &&
                     addr_reg[ADDR_W-1:ADDR_W-2] == SEG_TOP);
  assign hw_lock = protect_pin_enable_bit_reg & ~wp_s2_reg;
  assign go_arr = cs_rise && wok_s2_reg && !busy_reg && wel_reg &&
                  op_reg == OP_WRITE_ARRAY && !prot_arr;
  assign go_stat = cs_rise && wok_s2_reg && !busy_reg && wel_reg &&
                   op_reg == OP_WRITE_STATUS && !hw_lock;

  // Write engine: copy the page, or load the protect bits, then wait out
  // the self-timed cycle.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wstate_reg <= W_IDLE;
      busy_reg <= 1'b0;
      wel_reg <= 1'b0;
      protect_pin_enable_bit_reg <= PROTECT_PIN_ENABLE_BIT_RST;
      bp_reg <= BP_RST;
      idx_reg <= '0;
      wcnt_reg <= '0;
    end else begin
      case (wstate_reg)
        W_IDLE: begin
          idx_reg <= '0;
          if (go_arr) begin
            wstate_reg <= W_COPY;
            busy_reg <= 1'b1;
          end else if (go_stat) begin
            wstate_reg <= W_STAT;
            busy_reg <= 1'b1;
          end else if (cs_rise && lok_s2_reg) begin
            wel_reg <= (op_reg == OP_SET_WRITE_LATCH);
          end
        end
        W_COPY: begin
          idx_reg <= idx_reg + 5'h01;
          if (idx_reg == IDX_LAST) begin
            wstate_reg <= W_WAIT;
            wcnt_reg <= WCNT_W'(WRITE_CYCLES - 1);
          end
        end
        W_STAT: begin
          protect_pin_enable_bit_reg <= stat_data_reg[PROTECT_PIN_ENABLE_BIT];
          bp_reg <= stat_data_reg[BLOCK_PROTECT_HI:BLOCK_PROTECT_LO];
          wstate_reg <= W_WAIT;
          wcnt_reg <= WCNT_W'(WRITE_CYCLES - 1);
        end
        W_WAIT: begin
          if (wcnt_reg == '0) begin
            wstate_reg <= W_IDLE;
            busy_reg <= 1'b0;
            wel_reg <= 1'b0;
          end else begin
            wcnt_reg <= wcnt_reg - 18'h0_0001;
          end
        end
        default: wstate_reg <= W_IDLE;
      endcase
    end
  end

  // Array writes land from the page buffer, one byte slot per clock.
  always_ff @(posedge ref_clk_in) begin
    if (wstate_reg == W_COPY && mask_reg[idx_reg]) begin
      mem[{addr_reg[ADDR_W-1:OFS_W], idx_reg}] <= page_buf[idx_reg];
    end
  end

  // Status byte as the link will shift it out.
  always_comb begin
    stat_next = '0;
    stat_next[WRITE_BUSY_BIT] = busy_reg;
    stat_next[WRITE_LATCH_BIT] = wel_reg;
    stat_next[BLOCK_PROTECT_HI:BLOCK_PROTECT_LO] = bp_reg;
    stat_next[PROTECT_PIN_ENABLE_BIT] = protect_pin_enable_bit_reg;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      stat_rd_reg <= '0;
    end else if (busy_reg) begin
      stat_rd_reg <= STAT_BUSY_VAL;
    end else begin
      stat_rd_reg <= stat_next;
    end
  end

  // Checks on the local side.
  sequence s_commit_edge;
    cs_rise && wok_s2_reg && wel_reg;
  endsequence

  chk_commit_needs_edge: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    $rose(busy_reg) |-> $past(cs_rise) && $past(wok_s2_reg))
    else $error("write began without a whole-byte select rise");

  chk_commit_needs_wel: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    $rose(busy_reg) |-> $past(wel_reg))
    else $error("write began with write latch clear");

  chk_valid_starts: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    s_commit_edge ##0 (!busy_reg && op_reg == OP_WRITE_ARRAY && !prot_arr)
    |=> busy_reg && wstate_reg == W_COPY)
    else $error("valid array write did not start");

  chk_pin_lock: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    $rose(busy_reg) && wstate_reg == W_STAT |->
    !($past(protect_pin_enable_bit_reg) && !$past(wp_s2_reg)))
    else $error("status write passed a locked pin");

  chk_protect_top: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    wstate_reg == W_COPY |-> !prot_arr)
    else $error("write into protected array");

  chk_busy_reads_ones: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    busy_reg ##1 busy_reg |-> stat_rd_reg == STAT_BUSY_VAL)
    else $error("status not all ones while busy");

  chk_wait_end: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    wstate_reg == W_WAIT && wcnt_reg == '0 |=>
    !busy_reg && !wel_reg ##1 stat_rd_reg[WRITE_BUSY_BIT] == 1'b0)
    else $error("write end did not clear busy and latch");

  chk_copy_len: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    wstate_reg == W_COPY && idx_reg == IDX_LAST |=> wstate_reg == W_WAIT)
    else $error("page copy length wrong");

  // Checks on the link side.
  chk_read_incr: assert property (
    @(posedge sck_in) disable iff (srst_in)
    hold_n_in && !fresh_reg && phase_reg == PH_RDATA &&
    cnt_reg == BYTE_LAST |=> addr_reg == $past(addr_reg) + 11'h001)
    else $error("read address did not step");

  chk_page_stays: assert property (
    @(posedge sck_in) disable iff (srst_in)
    hold_n_in && !fresh_reg && phase_reg == PH_WDATA |=>
    addr_reg[ADDR_W-1:OFS_W] == $past(addr_reg[ADDR_W-1:OFS_W]))
    else $error("write address left its page");

  chk_dead_until_cs: assert property (
    @(posedge sck_in) disable iff (srst_in)
    phase_reg == PH_DEAD && !fresh_reg |=> phase_reg == PH_DEAD)
    else $error("instruction taken before select fall");

  chk_hold_freeze: assert property (
    @(posedge sck_in) disable iff (srst_in)
    !hold_n_in && !fresh_reg |=> cnt_reg == $past(cnt_reg))
    else $error("transfer moved while paused");

endmodule : see_spi_eeprom

`default_nettype wire

// ---- dv/see_host_model.sv ----
// Purpose: Behavioural host that drives the serial link of the EEPROM.
// Assumes: Mode 0 framing, 32 ns serial clock period, clock idles low.
// Notes: The data line is inverted whenever the host lets go of it.
`default_nettype none

module see_host_model (
  // Link lines toward the device.
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  output logic hold_n_out,
  // Serial data back from the device.
  input wire logic so_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Select starts low so the bench can try a frame with no falling edge.
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b0;
    si_out = 1'b0;
    hold_n_out = 1'b1;
  end

  // The deselect gap of over 2 us comes first, then the falling edge.
  task automatic start();
    #2100 cs_n_out <= 1'b0;
    #20;
  endtask

  // Shift n bits MSB first; the reply is taken on the rising edge.
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si_out <= tx[i];
      #8 sck_out <= 1'b1;
      rx[i] = so_in;
      #16 sck_out <= 1'b0;
      #8;
    end
  endtask

  // Select rises with the clock low, and the data line is let go.
  task automatic stop();
    #20 cs_n_out <= 1'b1;
    si_out <= ~si_out;
  endtask

  // Pause only moves while the clock is low, so callers sit between bits.
  task automatic set_hold(input logic v);
    hold_n_out <= v;
    #8;
  endtask
endmodule // see_host_model

`default_nettype wire

// ---- dv/see_spi_eeprom_tb.sv ----
// Purpose: Self-checking bench for the serial EEPROM command logic.
// Assumes: Write time shortened to 200 local clocks.
// Notes: Expected bytes come from a bench image of every committed write.
`default_nettype none

module see_spi_eeprom_tb import see_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WCYC = 200;
  logic ref_clk_in = 1'b0;
  // Reset starts low and is raised at time zero by the main sequence, so
  // the link's asynchronous clears see a real rising edge.
  logic srst_in = 1'b0;
  logic wp_n_in = 1'b1;
  logic sck, cs_n, si, hold_n, so, so_oe, busy;
  wire so_w;
  int fail_count = 0;
  int n_checks = 0;
  int seed = 48;
  logic [7:0] mem [MEM_BYTES];
  bit known [MEM_BYTES];
  logic m_pen = 1'b0;
  logic m_latch = 1'b0;
  logic [1:0] m_bp = 2'h0;
  logic [7:0] junk;

  // Local clock of 40 ns.
  always #20 ref_clk_in = ~ref_clk_in;

  // A released wire shows the inverse of the last bit, so a sample taken
  // while the device has let go can never pass by chance.
  assign so_w = so_oe ? so : ~so;

  see_spi_eeprom #(.WRITE_CYCLES(WCYC)) dut (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .sck_in(sck),
    .cs_n_in(cs_n), .si_in(si), .hold_n_in(hold_n), .so_out(so),
    .so_oe_out(so_oe), .wp_n_in(wp_n_in), .busy_out(busy)
  );

  see_host_model host (
    .sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n),
    .so_in(so_w)
  );

  // Compare with case equality so an unknown never matches.
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Single place where the run ends.
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Expected status byte while no write is running.
  function automatic logic [7:0] stat_val();
    return {m_pen, 3'h0, m_bp, m_latch, 1'b0};
  endfunction

  // Lowest guarded address for each protect setting.
  function automatic logic [10:0] prot_lo(input logic [1:0] bp);
    return (bp == BP_TOP_QUARTER) ? 11'h600 :
      (bp == BP_TOP_HALF) ? 11'h400 : 11'h000;
  endfunction

  // One opcode alone in its frame.
  task automatic op1(input logic [7:0] code);
    host.start();
    host.xfer(code, 8, junk);
    host.stop();
  endtask

  // Status frame; the byte is taken twice while clocks continue.
  task automatic rd_stat(input logic [7:0] exp);
    logic [7:0] got;
    host.start();
    host.xfer(OP_READ_STATUS, 8, got);
    repeat (2) begin
      host.xfer(8'($random(seed)), 8, got);
      check("status", got, exp);
    end
    host.stop();
  endtask

  // Busy must follow a committed write within a few clocks, then clear.
  task automatic commit_chk(input bit ok);
    int t;
    t = 0;
    while (busy !== 1'b1 && t < 10) begin
      @(negedge ref_clk_in);
      t++;
    end
    check("busy", {7'h0, busy}, {7'h0, ok});
    if (ok) begin
      rd_stat(STAT_BUSY_VAL);
      t = 0;
      while (busy !== 1'b0 && t < 400) begin
        @(negedge ref_clk_in);
        t++;
      end
      check("busy end", {7'h0, busy}, 8'h00);
      m_latch = 1'b0;
    end
    rd_stat(stat_val());
  endtask

  // Status write preceded by its own latch-set frame.
  task automatic wr_stat(input logic [7:0] v, input bit ok);
    op1(OP_SET_WRITE_LATCH);
    m_latch = 1'b1;
    host.start();
    host.xfer(OP_WRITE_STATUS, 8, junk);
    host.xfer(v, 8, junk);
    host.stop();
    if (ok) begin
      m_pen = v[PROTECT_PIN_ENABLE_BIT];
      m_bp = v[BLOCK_PROTECT_HI:BLOCK_PROTECT_LO];
    end
    commit_chk(ok);
  endtask

  // Array write of n bytes; a nonzero cut drops select inside the last.
  task automatic wr_arr(input logic [10:0] a, input int n, input int cut,
                        input bit ok);
    logic [7:0] d;
    logic [10:0] p;
    op1(OP_SET_WRITE_LATCH);
    m_latch = 1'b1;
    host.start();
    host.xfer(OP_WRITE_ARRAY, 8, junk);
    host.xfer({5'($random(seed)), a[10:8]}, 8, junk);
    host.xfer(a[7:0], 8, junk);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      p = {a[10:5], 5'(a[4:0] + i)};
      host.xfer(d, (cut > 0 && i == n - 1) ? cut : 8, junk);
      if (ok && cut == 0) begin
        mem[p] = d;
        known[p] = 1'b1;
      end
    end
    host.stop();
    commit_chk(ok && cut == 0);
  endtask

  // Pause with junk clocks; the output must let go meanwhile.
  task automatic pause();
    host.set_hold(1'b0);
    host.xfer(8'($random(seed)), 5, junk);
    check("paused oe", {7'h0, so_oe}, 8'h00);
    host.set_hold(1'b1);
  endtask

  // Array read of n bytes, optionally paused in address and in data.
  task automatic rd_arr(input logic [10:0] a, input int n, input bit hz);
    logic [7:0] got;
    logic [10:0] p;
    host.start();
    host.xfer(OP_READ_ARRAY, 8, junk);
    host.xfer({5'($random(seed)), a[10:8]}, 8, junk);
    if (hz) pause();
    host.xfer(a[7:0], 8, junk);
    for (int i = 0; i < n; i++) begin
      p = a + 11'(i);
      host.xfer(8'($random(seed)), 8, got);
      if (known[p]) check("read byte", got, mem[p]);
    end
    if (hz) pause();
    host.stop();
    #1 check("so released", {7'h0, so_oe}, 8'h00);
  endtask

  // Main sequence.
  initial begin
    logic [10:0] a;
    srst_in <= 1'b1;
    repeat (20) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(negedge ref_clk_in);
    check("oe after reset", {7'h0, so_oe}, 8'h00);
    check("busy after reset", {7'h0, busy}, 8'h00);
    host.xfer(OP_SET_WRITE_LATCH, 8, junk);
    host.stop();
    rd_stat(stat_val());
    $display("test power-up done");
    host.start();
    host.xfer(OP_SET_WRITE_LATCH, 8, junk);
    host.xfer(8'h00, 1, junk);
    host.stop();
    rd_stat(stat_val());
    op1(OP_SET_WRITE_LATCH);
    m_latch = 1'b1;
    rd_stat(stat_val());
    op1(OP_CLEAR_WRITE_LATCH);
    m_latch = 1'b0;
    rd_stat(stat_val());
    // A whole write frame with the latch clear must not start the engine.
    host.start();
    host.xfer(OP_WRITE_ARRAY, 8, junk);
    host.xfer(8'h00, 8, junk);
    host.xfer(8'h40, 8, junk);
    host.xfer(8'($random(seed)), 8, junk);
    host.stop();
    commit_chk(1'b0);
    $display("test write latch done");
    wr_arr(11'h7FE, 34, 0, 1'b1);
    wr_arr(11'h000, 1, 0, 1'b1);
    rd_arr(11'h7E0, 34, 1'b1);
    wr_arr(11'h7E4, 3, 3, 1'b0);
    rd_arr(11'h7E4, 3, 1'b0);
    $display("test page and wrap done");
    repeat (4) begin
      a = 11'($random(seed));
      wr_arr(a, 1 + ($random(seed) & 7), 0, 1'b1);
      rd_arr({a[10:5], 5'h00}, 32, 1'b0);
    end
    $display("test random writes done");
    for (int b = 1; b < 4; b++) begin
      wr_stat({4'h0, 2'(b), 2'h0}, 1'b1);
      wr_arr(prot_lo(2'(b)), 1, 0, 1'b0);
      rd_arr(prot_lo(2'(b)), 1, 1'b0);
      if (b < 3) wr_arr(prot_lo(2'(b)) - 11'h020, 1, 0, 1'b1);
    end
    wr_stat(8'h80, 1'b1);
    @(posedge ref_clk_in);
    wp_n_in <= 1'b0;
    wr_stat(8'h00, 1'b0);
    wr_arr(11'h020, 2, 0, 1'b1);
    @(posedge ref_clk_in);
    wp_n_in <= 1'b1;
    wr_stat(8'h00, 1'b1);
    $display("test protection done");
    end_of_test();
  end

  // Hang guard; the sequence needs well under a millisecond.
  initial begin
    #2_000_000;
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule // see_spi_eeprom_tb

`default_nettype wire
